// *** clk_gate_ctrl.sv ***
// peripheral clock gating and soft reset control, AHB-Lite register slave
// assumes power mode and port access requests come from logic on clk
`timescale 1ns/1ps
module clk_gate_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [31:0] capability_mask_a,
   input wire logic [31:0] capability_mask_b,
   input wire logic [31:0] capability_mask_ports,
   input wire logic [1:0] pwr_mode,
   input wire clk_gate_pkg::port_access_s port_access,
   output logic port_access_fault,
   output logic [clk_gate_pkg::PORT_COUNT-1:0] port_clk_en,
   output clk_gate_pkg::periph_rst_s periph_rst,
   output logic irq
);
   clk_gate_pkg::bus_state_e state_q;
   clk_gate_pkg::bus_state_e state_d;
   logic [11:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_val;
   logic take;
   logic wr_phase;
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_q;
   logic [31:0] clk_cfg_q;
   logic [31:0] irq_mask_q;
   logic [31:0] irq_status_q;
   logic [31:0] irq_status_d;
   logic [31:0] irq_set;
   logic [31:0] irq_clr;
   logic [clk_gate_pkg::PORT_COUNT-1:0] gate_sel;
   logic [clk_gate_pkg::PORT_COUNT-1:0] clk_en_q;
   logic fault_q;
   logic [1:0] mode_prev_q;
   clk_gate_pkg::periph_rst_s rst_q;
   logic we_a;
   logic we_b;
   logic we_ports;
   logic we_run;
   logic we_sleep;
   logic we_deep;
   logic we_cfg;
   logic we_mask;

   // bus: writes take no wait state, reads take one
   assign take = hsel && hready && htrans == clk_gate_pkg::HTRANS_NONSEQ;
   assign wr_phase = state_q == clk_gate_pkg::BUS_WRITE;
   assign hreadyout = state_q != clk_gate_pkg::BUS_READ_WAIT;
   assign hresp = clk_gate_pkg::HRESP_OKAY;
   assign hrdata = hrdata_q;

   always_comb begin
      state_d = clk_gate_pkg::BUS_IDLE;
      case (state_q)
         clk_gate_pkg::BUS_READ_WAIT: begin
            state_d = clk_gate_pkg::BUS_READ_DONE;
         end
         clk_gate_pkg::BUS_IDLE,
         clk_gate_pkg::BUS_WRITE,
         clk_gate_pkg::BUS_READ_DONE: begin
            if (take && hwrite) begin
               state_d = clk_gate_pkg::BUS_WRITE;
            end else if (take) begin
               state_d = clk_gate_pkg::BUS_READ_WAIT;
            end
         end
         default: begin
            state_d = clk_gate_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= clk_gate_pkg::BUS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         addr_q <= 12'h000;
      end else if (take && hreadyout) begin
         addr_q <= {haddr[11:2], 2'b00};
      end
   end

   // register writes land at the end of the data phase
   assign we_a = wr_phase && addr_q == clk_gate_pkg::OFF_SRST_A;
   assign we_b = wr_phase && addr_q == clk_gate_pkg::OFF_SRST_B;
   assign we_ports = wr_phase && addr_q == clk_gate_pkg::OFF_SRST_PORTS;
   assign we_run = wr_phase && addr_q == clk_gate_pkg::OFF_RUN_GATE;
   assign we_sleep = wr_phase && addr_q == clk_gate_pkg::OFF_SLEEP_GATE;
   assign we_deep = wr_phase && addr_q == clk_gate_pkg::OFF_DEEP_GATE;
   assign we_cfg = wr_phase && addr_q == clk_gate_pkg::OFF_CLK_CFG;
   assign we_mask = wr_phase && addr_q == clk_gate_pkg::OFF_IRQ_MASK;

   // soft reset registers, writes masked by capability inputs
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_SRST_A)) u_srst_a (
      .clk(clk), .nrst(nrst), .we(we_a), .wdata(hwdata),
      .cap(capability_mask_a), .q(rst_q.a)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_SRST_B)) u_srst_b (
      .clk(clk), .nrst(nrst), .we(we_b), .wdata(hwdata),
      .cap(capability_mask_b), .q(rst_q.b)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_PORTS)) u_srst_ports (
      .clk(clk), .nrst(nrst), .we(we_ports), .wdata(hwdata),
      .cap(capability_mask_ports), .q(rst_q.ports)
   );

   // the three port gate sets, the clock config and the interrupt mask
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_PORTS)) u_run_gate (
      .clk(clk), .nrst(nrst), .we(we_run), .wdata(hwdata),
      .cap(clk_gate_pkg::CAP_ALL), .q(run_gate_q)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_PORTS)) u_sleep_gate (
      .clk(clk), .nrst(nrst), .we(we_sleep), .wdata(hwdata),
      .cap(clk_gate_pkg::CAP_ALL), .q(sleep_gate_q)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_PORTS)) u_deep_gate (
      .clk(clk), .nrst(nrst), .we(we_deep), .wdata(hwdata),
      .cap(clk_gate_pkg::CAP_ALL), .q(deep_gate_q)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_CLK_CFG)) u_clk_cfg (
      .clk(clk), .nrst(nrst), .we(we_cfg), .wdata(hwdata),
      .cap(clk_gate_pkg::CAP_ALL), .q(clk_cfg_q)
   );
   masked_reg #(.IMPL(clk_gate_pkg::IMPL_IRQ)) u_irq_mask (
      .clk(clk), .nrst(nrst), .we(we_mask), .wdata(hwdata),
      .cap(clk_gate_pkg::CAP_ALL), .q(irq_mask_q)
   );

   // reset bits hold each peripheral until software clears them
   assign periph_rst = rst_q;

   // pick the gate set for the current power mode
   always_comb begin
      gate_sel = run_gate_q[clk_gate_pkg::PORT_COUNT-1:0];
      if (clk_cfg_q[clk_gate_pkg::AUTO_GATE_BIT]) begin
         case (pwr_mode)
            clk_gate_pkg::MODE_SLEEP: begin
               gate_sel = sleep_gate_q[clk_gate_pkg::PORT_COUNT-1:0];
            end
            clk_gate_pkg::MODE_DEEP: begin
               gate_sel = deep_gate_q[clk_gate_pkg::PORT_COUNT-1:0];
            end
            default: begin
               gate_sel = run_gate_q[clk_gate_pkg::PORT_COUNT-1:0];
            end
         endcase
      end
   end

   // glitch-free enables for the port clock gates
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clk_en_q <= '0;
      end else begin
         clk_en_q <= gate_sel;
      end
   end
   assign port_clk_en = clk_en_q;

   // an access to an unclocked port is answered by a fault
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= port_access.valid && !clk_en_q[port_access.port];
      end
   end
   assign port_access_fault = fault_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode_prev_q <= clk_gate_pkg::MODE_RUN;
      end else begin
         mode_prev_q <= pwr_mode;
      end
   end

   // sticky events, cleared by a status read; a new event wins
   always_comb begin
      irq_set = '0;
      irq_set[clk_gate_pkg::IRQ_FAULT_BIT] = fault_q;
      irq_set[clk_gate_pkg::IRQ_MODE_BIT] = mode_prev_q != pwr_mode;
      irq_clr = '0;
      if (state_q == clk_gate_pkg::BUS_READ_WAIT &&
          addr_q == clk_gate_pkg::OFF_IRQ_STATUS) begin
         irq_clr = clk_gate_pkg::CAP_ALL;
      end
      irq_status_d = (irq_status_q & ~irq_clr) | irq_set;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_status_q <= clk_gate_pkg::RESET_VAL;
      end else begin
         irq_status_q <= irq_status_d & clk_gate_pkg::IMPL_IRQ;
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);

   // read mux; unmapped addresses read zero
   always_comb begin
      case (addr_q)
         clk_gate_pkg::OFF_SRST_A: rd_val = rst_q.a;
         clk_gate_pkg::OFF_SRST_B: rd_val = rst_q.b;
         clk_gate_pkg::OFF_SRST_PORTS: rd_val = rst_q.ports;
         clk_gate_pkg::OFF_CLK_CFG: rd_val = clk_cfg_q;
         clk_gate_pkg::OFF_RUN_GATE: rd_val = run_gate_q;
         clk_gate_pkg::OFF_SLEEP_GATE: rd_val = sleep_gate_q;
         clk_gate_pkg::OFF_DEEP_GATE: rd_val = deep_gate_q;
         clk_gate_pkg::OFF_IRQ_STATUS: rd_val = irq_status_q;
         clk_gate_pkg::OFF_IRQ_MASK: rd_val = irq_mask_q;
         default: rd_val = clk_gate_pkg::RESET_VAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hrdata_q <= clk_gate_pkg::RESET_VAL;
      end else if (state_q == clk_gate_pkg::BUS_READ_WAIT) begin
         hrdata_q <= rd_val;
      end
   end

   // checks
   property p_gate_run;
      @(posedge clk) disable iff (!nrst)
      (pwr_mode == clk_gate_pkg::MODE_RUN) |=>
         clk_en_q == $past(run_gate_q[clk_gate_pkg::PORT_COUNT-1:0]);
   endproperty
   a_gate_run: assert property (p_gate_run)
      else $error("run mode does not use run gate set");

   property p_gate_sleep;
      @(posedge clk) disable iff (!nrst)
      (clk_cfg_q[clk_gate_pkg::AUTO_GATE_BIT] &&
       pwr_mode == clk_gate_pkg::MODE_SLEEP) |=>
         clk_en_q == $past(sleep_gate_q[clk_gate_pkg::PORT_COUNT-1:0]);
   endproperty
   a_gate_sleep: assert property (p_gate_sleep)
      else $error("sleep mode with auto gating ignores sleep set");

   property p_gate_no_auto;
      @(posedge clk) disable iff (!nrst)
      !clk_cfg_q[clk_gate_pkg::AUTO_GATE_BIT] |=>
         clk_en_q == $past(run_gate_q[clk_gate_pkg::PORT_COUNT-1:0]);
   endproperty
   a_gate_no_auto: assert property (p_gate_no_auto)
      else $error("without auto gating run set must apply");

   property p_fault;
      @(posedge clk) disable iff (!nrst)
      (port_access.valid && !port_clk_en[port_access.port]) |=>
         port_access_fault ##1 irq_status_q[clk_gate_pkg::IRQ_FAULT_BIT];
   endproperty
   a_fault: assert property (p_fault)
      else $error("access to unclocked port not faulted");

   property p_no_fault;
      @(posedge clk) disable iff (!nrst)
      (port_access.valid && port_clk_en[port_access.port]) |=>
         !port_access_fault;
   endproperty
   a_no_fault: assert property (p_no_fault)
      else $error("clocked port access faulted");

   property p_reset_zero;
      @(posedge clk)
      !nrst |=> (port_clk_en == '0 && periph_rst == '0 &&
                 deep_gate_q == clk_gate_pkg::RESET_VAL);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("registers not cleared by reset");

   property p_cap_mask;
      @(posedge clk) disable iff (!nrst)
      we_b |=> (rst_q.b & ~$past(capability_mask_b)) ==
               ($past(rst_q.b) & ~$past(capability_mask_b));
   endproperty
   a_cap_mask: assert property (p_cap_mask)
      else $error("masked reset bit changed on write");

   property p_reserved_zero;
      @(posedge clk) disable iff (!nrst)
      (rst_q.a & ~clk_gate_pkg::IMPL_SRST_A) == '0 &&
      (rst_q.b & ~clk_gate_pkg::IMPL_SRST_B) == '0 &&
      (rst_q.ports & ~clk_gate_pkg::IMPL_PORTS) == '0 &&
      (run_gate_q & ~clk_gate_pkg::IMPL_PORTS) == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_rst_hold;
      @(posedge clk) disable iff (!nrst)
      (rst_q.ports[0] && !we_ports) |=> periph_rst.ports[0];
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("port reset released without a write");

   property p_read_wait;
      @(posedge clk) disable iff (!nrst)
      (take && hreadyout && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read answer not after one wait state");

   c_sleep_gate: cover property (@(posedge clk) disable iff (!nrst)
      clk_cfg_q[clk_gate_pkg::AUTO_GATE_BIT] &&
      pwr_mode == clk_gate_pkg::MODE_SLEEP ##1 port_clk_en != '0);
   c_fault: cover property (@(posedge clk) disable iff (!nrst)
      port_access_fault ##1 irq);
   c_srst: cover property (@(posedge clk) disable iff (!nrst)
      we_a ##1 rst_q.a != '0);
endmodule

// *** clk_gate_ctrl_covers_note.sv ***
// holds no logic: the block's cover properties sit beside its assertions

// *** clk_gate_pkg.sv ***
// constants, register map and carrier types for the peripheral clock gate
// and soft reset block; shared by the block and its register cell
package clk_gate_pkg;

   // register byte offsets
   localparam logic [11:0] OFF_SRST_A = 12'h040;
   localparam logic [11:0] OFF_SRST_B = 12'h044;
   localparam logic [11:0] OFF_SRST_PORTS = 12'h048;
   localparam logic [11:0] OFF_CLK_CFG = 12'h060;
   localparam logic [11:0] OFF_RUN_GATE = 12'h108;
   localparam logic [11:0] OFF_SLEEP_GATE = 12'h118;
   localparam logic [11:0] OFF_DEEP_GATE = 12'h128;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h150;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h154;

   localparam logic [31:0] RESET_VAL = 32'h0000_0000;

   // writable bits of each register
   localparam logic [31:0] IMPL_SRST_A = 32'h0011_0008;
   localparam logic [31:0] IMPL_SRST_B = 32'h0107_0013;
   localparam logic [31:0] IMPL_PORTS = 32'h0000_001f;
   localparam logic [31:0] IMPL_CLK_CFG = 32'h0000_0001;
   localparam logic [31:0] IMPL_IRQ = 32'h0000_0003;
   localparam logic [31:0] CAP_ALL = 32'hffff_ffff;

   // field positions
   localparam int AUTO_GATE_BIT = 0;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_MODE_BIT = 1;
   localparam int PORT_COUNT = 5;
   localparam int PORT_IDX_W = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP = 2'b10
   } pwr_mode_e;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ_WAIT = 2'b10,
      BUS_READ_DONE = 2'b11
   } bus_state_e;

   typedef struct packed {
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] ports;
   } periph_rst_s;

   typedef struct packed {
      logic valid;
      logic [PORT_IDX_W-1:0] port;
   } port_access_s;

endpackage

// *** masked_reg.sv ***
// one 32-bit control register with fixed writable bits and a write mask
// assumes write enable and data come from the bus logic on the same clock
`timescale 1ns/1ps
module masked_reg #(
   parameter logic [31:0] IMPL = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic we,
   input wire logic [31:0] wdata,
   input wire logic [31:0] cap,
   output logic [31:0] q
);
   logic [31:0] wmask;

   // only implemented bits the capability mask allows may change
   assign wmask = IMPL & cap;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= clk_gate_pkg::RESET_VAL;
      end else if (we) begin
         q <= (q & ~wmask) | (wdata & wmask);
      end
   end
endmodule

// *** peripheral_clock_gate_and_soft_reset_tb_top.sv ***
// self-checking bench for the clock gate and soft reset block
// assumes one 100 MHz clock, a single AHB-Lite master and hready = hreadyout
`timescale 1ns/1ps
module peripheral_clock_gate_and_soft_reset_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] cap [3] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
   logic [1:0] pwr_mode = 2'h0;
   clk_gate_pkg::port_access_s port_access = '0;
   logic port_access_fault;
   logic [4:0] port_clk_en;
   clk_gate_pkg::periph_rst_s periph_rst;
   logic irq;
   logic [31:0] exp_q [$];
   logic rd_pend = 1'b0;
   int fails = 0;
   int cmp_count = 0;
   logic [11:0] offs [3] = '{12'h040, 12'h044, 12'h048};
   logic [31:0] impl [3] = '{clk_gate_pkg::IMPL_SRST_A,
      clk_gate_pkg::IMPL_SRST_B, clk_gate_pkg::IMPL_PORTS};
   logic [31:0] model [3] = '{32'h0, 32'h0, 32'h0};
   logic [1:0] modes [4] = '{2'b01, 2'b10, 2'b00, 2'b11};

   clk_gate_ctrl u_clk_gate_ctrl (
      .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .capability_mask_a(cap[0]),
      .capability_mask_b(cap[1]), .capability_mask_ports(cap[2]),
      .pwr_mode(pwr_mode), .port_access(port_access),
      .port_access_fault(port_access_fault), .port_clk_en(port_clk_en),
      .periph_rst(periph_rst), .irq(irq)
   );

   always #5 clk = ~clk;

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch hrdata expected %h seen %h", exp, got);
      end
   endtask

   task automatic chk_lvl(input string nm, input logic [95:0] exp,
                          input logic [95:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bounded wait for the slave to sample hready high
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            conclude();
         end
         @(posedge clk);
      end
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= clk_gate_pkg::HTRANS_NONSEQ;
      haddr <= {20'h0_0000, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wr ? d : ~d;
      wait_ready();
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      xfer(1'b0, a, 32'h0000_0000);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic access(input logic [2:0] p, input logic exp);
      @(posedge clk);
      port_access <= '{1'b1, p};
      @(posedge clk);
      port_access <= '0;
      #1;
      chk_lvl("fault", {95'h0, exp}, {95'h0, port_access_fault});
   endtask

   // read data monitor: oldest noted value against the completed read
   always @(posedge clk) begin
      if (rd_pend && hreadyout === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("mismatch hrdata expected none seen %h", hrdata);
         end else
            chk_rd(exp_q.pop_front(), hrdata);
         chk_lvl("hresp", {95'h0, clk_gate_pkg::HRESP_OKAY}, {95'h0, hresp});
      end
      if (hreadyout === 1'b1)
         rd_pend = nrst && hsel && htrans == clk_gate_pkg::HTRANS_NONSEQ
                   && !hwrite;
   end

   initial begin
      logic [31:0] c;
      logic [31:0] d;
      logic [4:0] ge;
      void'($urandom(51986));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      foreach (offs[i]) rd(offs[i], 32'h0000_0000);
      rd(12'h108, 32'h0000_0000);
      rd(12'h118, 32'h0000_0000);
      rd(12'h128, 32'h0000_0000);
      rd(12'h150, 32'h0000_0000);
      chk_lvl("port_clk_en", 96'h0, {91'h0, port_clk_en});
      chk_lvl("periph_rst", 96'h0, periph_rst);
      $display("test reset values done");
      foreach (offs[r]) begin
         for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 32'hffff_ffff : $urandom;
            d = (k == 3) ? 32'h0000_0000 : $urandom | (k == 0 ? ~0 : 0);
            cap[r] <= c;
            xfer(1'b1, offs[r], d);
            model[r] = ((model[r] & ~c) | (d & c)) & impl[r];
            rd(offs[r], model[r]);
         end
         cap[r] <= 32'hffff_ffff;
      end
      cyc(1);
      chk_lvl("periph_rst", {model[0], model[1], model[2]}, periph_rst);
      xfer(1'b1, 12'h200, 32'hffff_ffff);
      rd(12'h200, 32'h0000_0000);
      $display("test soft reset masking done");
      xfer(1'b1, 12'h108, 32'hffff_ffff);
      rd(12'h108, 32'h0000_001f);
      xfer(1'b1, 12'h108, 32'h0000_001b);
      cyc(2);
      chk_lvl("port_clk_en", 96'h1b, {91'h0, port_clk_en});
      for (int p = 0; p < 5; p++) access(p[2:0], p == 2);
      $display("test port gating done");
      xfer(1'b1, 12'h118, 32'h0000_0005);
      xfer(1'b1, 12'h128, 32'h0000_000a);
      for (int auto_on = 0; auto_on < 2; auto_on++) begin
         xfer(1'b1, 12'h060, auto_on);
         foreach (modes[m]) begin
            @(posedge clk) pwr_mode <= modes[m];
            cyc(3);
            ge = 5'h1b;
            if (auto_on == 1 && modes[m] == 2'b01)
               ge = 5'h05;
            if (auto_on == 1 && modes[m] == 2'b10)
               ge = 5'h0a;
            chk_lvl("port_clk_en", {91'h0, ge}, {91'h0, port_clk_en});
         end
      end
      $display("test power modes done");
      rd(12'h150, 32'h0000_0003);
      xfer(1'b1, 12'h154, 32'h0000_0001);
      rd(12'h154, 32'h0000_0001);
      cyc(1);
      chk_lvl("irq", 96'h0, {95'h0, irq});
      access(3'h2, 1'b1);
      cyc(3);
      chk_lvl("irq", 96'h1, {95'h0, irq});
      @(posedge clk) pwr_mode <= 2'b01;
      cyc(3);
      rd(12'h150, 32'h0000_0003);
      cyc(1);
      chk_lvl("irq", 96'h0, {95'h0, irq});
      xfer(1'b1, 12'h154, 32'h0000_0002);
      pwr_mode <= 2'b00;
      cyc(3);
      chk_lvl("irq", 96'h1, {95'h0, irq});
      rd(12'h150, 32'h0000_0002);
      cyc(1);
      chk_lvl("irq", 96'h0, {95'h0, irq});
      $display("test interrupts done");
      cyc(2);
      if (exp_q.size() != 0) begin
         fails++;
         $display("mismatch reads expected %0d more seen 0", exp_q.size());
      end
      conclude();
   end
endmodule
